// ===== src/calendar_clock_pkg.sv
// Calendar clock register block constants and types
//Function
// - Alarm pointer picks the alarm pair: 00 min/sec, 01 weekday/hour, 10 month/day.
// - Alarm window high byte write decrements alarm pointer, holding at 00.
// - Any read of either window decrements that window's pointer.
// - Time pointer decrements on any read or a high byte write; 11 exposes the year.
// - Time value writes are ignored unless the write-enable bit 13 is set.
// - Write-enable sets only just after key writes 0x55 then 0xAA.
// - Enable bit 15 runs the clock; writing it needs write-enable set.
// - Read-only sync bit 12 is high while a rollover ripple may occur.
// - Bit 11 is high in the second half-second; cleared by seconds write.
// - Output pin gives seconds clock or alarm pulse, only while bit 10 set.
// - Signed calibration adds or subtracts four pulses per unit each minute.
// - Calibration/configuration register clears only on power-on reset.
// - Four-bit mask selects which time digits must match for the alarm.
// - Year holds two BCD digits in the low byte; upper byte reads zero.
// - Month/day layout: month in bits 12-8 (read-only in the time window), day in bits 5-0.
// - Each alarm decrements the repeat count; at 00h one final alarm, or a reload to FFh with chime set.
package calendar_clock_pkg;
  localparam logic [2:0]  OFS_CFG     = 3'h0;
  localparam logic [2:0]  OFS_PAD     = 3'h1;
  localparam logic [2:0]  OFS_ALCFG   = 3'h2;
  localparam logic [2:0]  OFS_TWIN    = 3'h3;
  localparam logic [2:0]  OFS_AWIN    = 3'h4;
  localparam logic [2:0]  OFS_KEY     = 3'h5;
  localparam int          CLK_HZ      = 25000000;
  localparam int          TB_HZ       = 32768;
  localparam int          ACC_W       = 25;
  localparam int          PRE_W       = 18;
  localparam int          TB_LAST     = TB_HZ - 1;
  localparam int          TB_HALF     = TB_HZ / 2;
  localparam int          SYNC_WIN    = 32;
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'hAA;
  localparam logic [1:0]  UNLOCK_CYC  = 2'h2;
  localparam int          B_EN        = 15;
  localparam int          B_WREN      = 13;
  localparam int          B_OE        = 10;
  localparam int          B_ALEN      = 15;
  localparam int          B_CHIME     = 14;
  localparam logic [7:0]  RPT_MAX     = 8'hFF;
  localparam logic [1:0]  PTR_ZERO    = 2'h0;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        rd;
  } calendar_clock_req_t;

  typedef struct packed {
    logic [7:0] yr;
    logic [7:0] mon;
    logic [7:0] day;
    logic [7:0] wd;
    logic [7:0] hr;
    logic [7:0] min;
    logic [7:0] sec;
  } calendar_clock_time_t;

  localparam calendar_clock_time_t TIME_RST = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage

// ===== src/calendar_clock_regs.sv
// Calendar clock with alarm, unlock gate and windowed value registers
// Clock rate is a parameter so a bench can run the timebase at full speed
//
// Strobed register access and the placing of the registers are this design's own decisions.
module calendar_clock_regs #(
  parameter int CLK_HZ = calendar_clock_pkg::CLK_HZ
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire calendar_clock_pkg::calendar_clock_req_t req,
  output logic [15:0]             rdata,
  output logic                    clock_out,
  output logic                    clock_out_oe,
  output logic                    alarm_event
);
  logic [calendar_clock_pkg::ACC_W-1:0]        acc_q;
  logic                              tb_tick;
  logic signed [calendar_clock_pkg::PRE_W-1:0] pre_q;
  logic signed [calendar_clock_pkg::PRE_W-1:0] cal_ld;
  logic                              sec_tick, half_tick, half_flag, sync_flag;
  logic                              en_q, wren_q, oe_q, sel_q, ttl_q;
  logic [1:0]                        tptr_q, aptr_q, unlock_q;
  logic                              key_arm_q;
  logic [7:0]                        cal_q, rpt_q;
  logic                              alen_q, chime_q;
  logic [3:0]                        mask_q;
  calendar_clock_pkg::calendar_clock_time_t              tm_q, tm_nx, al_q;
  logic [7:0]                        mdays;
  logic                              leap, chk_sec_q, chk_half_q, hit, tog_q;
  logic                              m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo;
  logic                              wr_cfg, wr_tw, wr_aw, rd_tw, rd_aw, tw_sec_wr;
  logic [15:0]                       rdata_q;

  assign wr_cfg    = req.wr && req.addr == calendar_clock_pkg::OFS_CFG;
  assign wr_tw     = req.wr && req.addr == calendar_clock_pkg::OFS_TWIN;
  assign wr_aw     = req.wr && req.addr == calendar_clock_pkg::OFS_AWIN;
  assign rd_tw     = req.rd && req.addr == calendar_clock_pkg::OFS_TWIN;
  assign rd_aw     = req.rd && req.addr == calendar_clock_pkg::OFS_AWIN;
  assign tw_sec_wr = wr_tw && wren_q && req.be[0] && tptr_q == calendar_clock_pkg::PTR_ZERO;

  function automatic logic [7:0] bcd_nx(input logic [7:0] v, input logic [7:0] last,
                                        input logic [7:0] first);
    if (v == last) return first;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction

  // Fractional divider gives an exact 32.768 kHz average rate
  always_ff @(posedge clk) begin
    if (!resetn) acc_q <= '0;
    else if (acc_q >= calendar_clock_pkg::ACC_W'(CLK_HZ - calendar_clock_pkg::TB_HZ))
      acc_q <= acc_q - calendar_clock_pkg::ACC_W'(CLK_HZ - calendar_clock_pkg::TB_HZ);
    else acc_q <= acc_q + calendar_clock_pkg::ACC_W'(calendar_clock_pkg::TB_HZ);
  end
  assign tb_tick = en_q && acc_q >= calendar_clock_pkg::ACC_W'(CLK_HZ - calendar_clock_pkg::TB_HZ);

  assign sec_tick  = tb_tick && pre_q >= calendar_clock_pkg::PRE_W'(calendar_clock_pkg::TB_LAST);
  assign half_tick = tb_tick && pre_q == calendar_clock_pkg::PRE_W'(calendar_clock_pkg::TB_HALF - 1);
  assign half_flag = pre_q >= calendar_clock_pkg::PRE_W'(calendar_clock_pkg::TB_HALF);
  assign sync_flag = en_q && pre_q >= calendar_clock_pkg::PRE_W'(calendar_clock_pkg::TB_HZ - calendar_clock_pkg::SYNC_WIN);
  // Calibration in units of four pulses, sign-extended
  assign cal_ld = calendar_clock_pkg::PRE_W'({{(calendar_clock_pkg::PRE_W-10){cal_q[7]}}, cal_q, 2'b00});

  always_ff @(posedge clk) begin
    if (!resetn) pre_q <= '0;
    else if (tw_sec_wr) pre_q <= '0;
    else if (sec_tick) pre_q <= (tm_q.sec == 8'h59) ? cal_ld : '0;
    else if (tb_tick) pre_q <= pre_q + calendar_clock_pkg::PRE_W'(1);
  end

  // Days in month with a four-year leap rule on the BCD year
  assign leap = tm_q.yr[4] ? (tm_q.yr[3:0] == 4'h2 || tm_q.yr[3:0] == 4'h6)
                           : (tm_q.yr[3:0] == 4'h0 || tm_q.yr[3:0] == 4'h4 ||
                              tm_q.yr[3:0] == 4'h8);
  always_comb begin
    case (tm_q.mon)
      8'h02:                      mdays = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
      default:                    mdays = 8'h31;
    endcase
  end

  always_comb begin
    tm_nx     = tm_q;
    tm_nx.sec = bcd_nx(tm_q.sec, 8'h59, 8'h00);
    if (tm_q.sec == 8'h59) begin
      tm_nx.min = bcd_nx(tm_q.min, 8'h59, 8'h00);
      if (tm_q.min == 8'h59) begin
        tm_nx.hr = bcd_nx(tm_q.hr, 8'h23, 8'h00);
        if (tm_q.hr == 8'h23) begin
          tm_nx.wd  = bcd_nx(tm_q.wd, 8'h06, 8'h00);
          tm_nx.day = bcd_nx(tm_q.day, mdays, 8'h01);
          if (tm_q.day == mdays) begin
            tm_nx.mon = bcd_nx(tm_q.mon, 8'h12, 8'h01);
            if (tm_q.mon == 8'h12) tm_nx.yr = bcd_nx(tm_q.yr, 8'h99, 8'h00);
          end
        end
      end
    end
  end

  // A software write in the tick cycle wins over the advance
  always_ff @(posedge clk) begin
    if (!resetn) tm_q <= calendar_clock_pkg::TIME_RST;
    else if (wr_tw && wren_q) begin
      case (tptr_q)
        2'h0: begin
          if (req.be[1]) tm_q.min <= {1'b0, req.wdata[14:8]};
          if (req.be[0]) tm_q.sec <= {1'b0, req.wdata[6:0]};
        end
        2'h1: begin
          if (req.be[1]) tm_q.wd <= {5'h00, req.wdata[10:8]};
          if (req.be[0]) tm_q.hr <= {2'h0, req.wdata[5:0]};
        end
        2'h2: if (req.be[0]) tm_q.day <= {2'h0, req.wdata[5:0]};
        default: if (req.be[0]) tm_q.yr <= req.wdata[7:0];
      endcase
    end
    else if (sec_tick) tm_q <= tm_nx;
  end

  // Unlock sequence opens a short window for setting write-enable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      key_arm_q <= 1'b0;
      unlock_q  <= '0;
    end
    else if (req.wr && req.addr == calendar_clock_pkg::OFS_KEY && req.be[0]) begin
      key_arm_q <= req.wdata[7:0] == calendar_clock_pkg::KEY_FIRST;
      unlock_q  <= (key_arm_q && req.wdata[7:0] == calendar_clock_pkg::KEY_SECOND) ?
                   calendar_clock_pkg::UNLOCK_CYC : '0;
    end
    else if (unlock_q != '0) unlock_q <= unlock_q - 2'h1;
  end

  // Only resetn clears this register; it stands for power-on reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_q   <= 1'b0;
      wren_q <= 1'b0;
      oe_q   <= 1'b0;
      tptr_q <= '0;
      cal_q  <= '0;
    end
    else if (wr_cfg) begin
      if (req.be[1]) begin
        if (wren_q) en_q <= req.wdata[calendar_clock_pkg::B_EN];
        if (!req.wdata[calendar_clock_pkg::B_WREN] || unlock_q != '0)
          wren_q <= req.wdata[calendar_clock_pkg::B_WREN];
        oe_q   <= req.wdata[calendar_clock_pkg::B_OE];
        tptr_q <= req.wdata[9:8];
      end
      if (req.be[0]) cal_q <= req.wdata[7:0];
    end
    else if ((rd_tw || (wr_tw && req.be[1])) && tptr_q != calendar_clock_pkg::PTR_ZERO)
      tptr_q <= tptr_q - 2'h1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_q <= 1'b0;
      ttl_q <= 1'b0;
    end
    else if (req.wr && req.addr == calendar_clock_pkg::OFS_PAD && req.be[0]) begin
      sel_q <= req.wdata[1];
      ttl_q <= req.wdata[0];
    end
  end

  // Alarm value window; no lock applies here
  always_ff @(posedge clk) begin
    if (!resetn) al_q <= calendar_clock_pkg::TIME_RST;
    else if (wr_aw) begin
      case (aptr_q)
        2'h0: begin
          if (req.be[1]) al_q.min <= {1'b0, req.wdata[14:8]};
          if (req.be[0]) al_q.sec <= {1'b0, req.wdata[6:0]};
        end
        2'h1: begin
          if (req.be[1]) al_q.wd <= {5'h00, req.wdata[10:8]};
          if (req.be[0]) al_q.hr <= {2'h0, req.wdata[5:0]};
        end
        2'h2: begin
          if (req.be[1]) al_q.mon <= {3'h0, req.wdata[12:8]};
          if (req.be[0]) al_q.day <= {2'h0, req.wdata[5:0]};
        end
        default: ;
      endcase
    end
  end

  // Match checked one cycle after the tick, on the updated time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chk_sec_q  <= 1'b0;
      chk_half_q <= 1'b0;
    end
    else begin
      chk_sec_q  <= sec_tick;
      chk_half_q <= half_tick;
    end
  end

  assign m_s1 = al_q.sec[3:0] == tm_q.sec[3:0];
  assign m_s  = al_q.sec == tm_q.sec;
  assign m_m1 = al_q.min[3:0] == tm_q.min[3:0];
  assign m_m  = al_q.min == tm_q.min;
  assign m_h  = al_q.hr == tm_q.hr;
  assign m_w  = al_q.wd == tm_q.wd;
  assign m_d  = al_q.day == tm_q.day;
  assign m_mo = al_q.mon == tm_q.mon;

  always_comb begin
    case (mask_q)
      4'h0:    hit = chk_sec_q || chk_half_q;
      4'h1:    hit = chk_sec_q;
      4'h2:    hit = chk_sec_q && m_s1;
      4'h3:    hit = chk_sec_q && m_s;
      4'h4:    hit = chk_sec_q && m_s && m_m1;
      4'h5:    hit = chk_sec_q && m_s && m_m;
      4'h6:    hit = chk_sec_q && m_s && m_m && m_h;
      4'h7:    hit = chk_sec_q && m_s && m_m && m_h && m_w;
      4'h8:    hit = chk_sec_q && m_s && m_m && m_h && m_d;
      4'h9:    hit = chk_sec_q && m_s && m_m && m_h && m_d && m_mo;
      default: hit = 1'b0;
    endcase
  end

  assign alarm_event = alen_q && hit;

  // Alarm event overrides a same-cycle software write of the count, or of enable on the final alarm
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alen_q  <= 1'b0;
      chime_q <= 1'b0;
      mask_q  <= '0;
      aptr_q  <= '0;
      rpt_q   <= '0;
    end
    else begin
      if (req.wr && req.addr == calendar_clock_pkg::OFS_ALCFG) begin
        if (req.be[1]) begin
          alen_q  <= req.wdata[calendar_clock_pkg::B_ALEN];
          chime_q <= req.wdata[calendar_clock_pkg::B_CHIME];
          mask_q  <= req.wdata[13:10];
          aptr_q  <= req.wdata[9:8];
        end
        if (req.be[0]) rpt_q <= req.wdata[7:0];
      end
      else if ((rd_aw || (wr_aw && req.be[1])) && aptr_q != calendar_clock_pkg::PTR_ZERO)
        aptr_q <= aptr_q - 2'h1;
      if (alarm_event) begin
        if (rpt_q != '0) rpt_q <= rpt_q - 8'h01;
        else if (chime_q) rpt_q <= calendar_clock_pkg::RPT_MAX;
        else alen_q <= 1'b0;
      end
    end
  end

  // Alarm pulse toggles per event, giving a visible edge on the pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tog_q     <= 1'b0;
      clock_out <= 1'b0;
    end
    else begin
      if (alarm_event) tog_q <= ~tog_q;
      clock_out <= oe_q && (sel_q ? half_flag : tog_q);
    end
  end
  assign clock_out_oe = oe_q;

  always_ff @(posedge clk) begin
    if (!resetn) rdata_q <= '0;
    else if (req.rd) begin
      if (req.addr == calendar_clock_pkg::OFS_CFG)
        rdata_q <= {en_q, 1'b0, wren_q, sync_flag, half_flag, oe_q, tptr_q, cal_q};
      else if (req.addr == calendar_clock_pkg::OFS_PAD) rdata_q <= {14'h0000, sel_q, ttl_q};
      else if (req.addr == calendar_clock_pkg::OFS_ALCFG)
        rdata_q <= {alen_q, chime_q, mask_q, aptr_q, rpt_q};
      else if (rd_tw) begin
        case (tptr_q)
          2'h0:    rdata_q <= {tm_q.min, tm_q.sec};
          2'h1:    rdata_q <= {tm_q.wd, tm_q.hr};
          2'h2:    rdata_q <= {tm_q.mon, tm_q.day};
          default: rdata_q <= {8'h00, tm_q.yr};
        endcase
      end
      else if (rd_aw) begin
        case (aptr_q)
          2'h0:    rdata_q <= {al_q.min, al_q.sec};
          2'h1:    rdata_q <= {al_q.wd, al_q.hr};
          2'h2:    rdata_q <= {al_q.mon, al_q.day};
          default: rdata_q <= '0;
        endcase
      end
      else rdata_q <= '0;
    end
  end
  assign rdata = rdata_q;

  a_tptr_step: assert property (@(posedge clk) disable iff (!resetn)
    (rd_tw || (wr_tw && req.be[1])) && tptr_q != 2'h0 |=> tptr_q == $past(tptr_q) - 2'h1)
    else $error("time pointer did not step down");
  a_aptr_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_aw && req.be[1] |=> aptr_q == (($past(aptr_q) == 2'h0) ? 2'h0 : $past(aptr_q) - 2'h1))
    else $error("alarm pointer wrong after high write");
  a_aptr_read: assert property (@(posedge clk) disable iff (!resetn)
    rd_aw && aptr_q == 2'h2 |=> aptr_q == 2'h1)
    else $error("alarm pointer not stepped by read");
  a_time_locked: assert property (@(posedge clk) disable iff (!resetn)
    wr_tw && !wren_q && !sec_tick |=> $stable(tm_q))
    else $error("locked time value changed");
  a_wren_unlock: assert property (@(posedge clk) disable iff (!resetn)
    $rose(wren_q) |-> $past(unlock_q != 2'h0))
    else $error("write enable set without unlock");
  a_en_gated: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && en_q != $past(en_q) |-> $past(wren_q))
    else $error("enable changed while locked");
  a_half_clear: assert property (@(posedge clk) disable iff (!resetn)
    tw_sec_wr |=> !half_flag ##1 !half_flag)
    else $error("half second flag not cleared");
  a_out_gate: assert property (@(posedge clk) disable iff (!resetn)
    !oe_q |=> !clock_out)
    else $error("clock output active while disabled");
  a_alarm_last: assert property (@(posedge clk) disable iff (!resetn)
    alarm_event && rpt_q == 8'h00 && !chime_q |=> !alen_q && !alarm_event)
    else $error("alarm enable not cleared after last alarm");
  a_chime_roll: assert property (@(posedge clk) disable iff (!resetn)
    alarm_event && rpt_q == 8'h00 && chime_q |=> rpt_q == 8'hFF && alen_q)
    else $error("repeat count did not roll over");
  a_year_read: assert property (@(posedge clk) disable iff (!resetn)
    rd_tw && tptr_q == 2'h3 |=> rdata[15:8] == 8'h00 && rdata[7:0] == $past(tm_q.yr))
    else $error("year read wrong");
  a_month_ro: assert property (@(posedge clk) disable iff (!resetn)
    wr_tw && tptr_q == 2'h2 && !sec_tick |=> tm_q.mon == $past(tm_q.mon))
    else $error("month written through time window");
  a_rpt_step: assert property (@(posedge clk) disable iff (!resetn)
    alarm_event && rpt_q != 8'h00 |=> rpt_q == $past(rpt_q) - 8'h01)
    else $error("repeat count not decremented");
  a_mask_reserved: assert property (@(posedge clk) disable iff (!resetn)
    mask_q > 4'h9 |-> !alarm_event)
    else $error("reserved mask raised an alarm");
endmodule // calendar_clock_regs

// ===== tb/tb.sv
// Register-level testbench for the calendar clock block
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk;
  logic                resetn;
  calendar_clock_pkg::calendar_clock_req_t req;
  logic [15:0]         rdata;
  logic                clock_out;
  logic                clock_out_oe;
  logic                alarm_event;
  int                  err_total;
  int                  comparisons;
  int                  alarm_seen = 0;

  // Timebase ticks every clock so seconds and alarms fit in the run
  calendar_clock_regs #(
    .CLK_HZ (calendar_clock_pkg::TB_HZ)
  ) calendar_clock_regs_i (
    .clk          (clk),
    .resetn       (resetn),
    .req          (req),
    .rdata        (rdata),
    .clock_out    (clock_out),
    .clock_out_oe (clock_out_oe),
    .alarm_event  (alarm_event)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Alarm pulses counted mid-cycle, where the pulse stands
  always @(negedge clk) begin
    if (alarm_event === 1'b1) alarm_seen <= alarm_seen + 1;
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Strobe stays up on return, so every call is followed by another call or idle
  task automatic wr(input logic [2:0] a, input logic [1:0] lanes, input logic [15:0] d);
    req <= '{addr: a, wdata: d, be: lanes, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input string name, input logic [15:0] exp);
    req <= '{addr: a, wdata: 16'h0000, be: 2'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    // Idle edge leaves the read data untouched, so it is checked here
    @(posedge clk);
    chk(name, exp, rdata);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask

  // Key pair then config high byte in the very next cycle
  task automatic unlock_cfg(input logic [15:0] d);
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h0055);
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h00AA);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, d);
  endtask

  initial begin
    // Tests need about 50k cycles
    #(40 * 60000);
    err_total++;
    $display("unexpected watchdog: expected 0, seen 1");
    results();
  end

  initial begin
    resetn      = 1'b0;
    req         = '0;
    err_total   = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Reset state
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h0000);
    chk("oe", 16'h0000, 16'(clock_out_oe));
    chk("pin", 16'h0000, 16'(clock_out));
    chk("alarm", 16'h0000, 16'(alarm_event));
    rd(calendar_clock_pkg::OFS_PAD, "pad", 16'h0000);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h0000);
    rd(calendar_clock_pkg::OFS_KEY, "key", 16'h0000);
    rd(3'h6, "unmapped6", 16'h0000);
    rd(3'h7, "unmapped7", 16'h0000);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h0000);
    // Locked: time and enable writes dropped
    wr(calendar_clock_pkg::OFS_TWIN, 2'h3, 16'h1234);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h0000);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, 16'h8000);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h0000);
    // Key in wrong order, then correct order with a gap
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h00AA);
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h0055);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, 16'h2000);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h0000);
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h0055);
    wr(calendar_clock_pkg::OFS_KEY, 2'h1, 16'h00AA);
    idle(3);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, 16'h2000);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h0000);
    // Time window walk from pointer 11 down to 00
    unlock_cfg(16'h2300);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2300);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h1, 16'h0025);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2300);
    rd(calendar_clock_pkg::OFS_TWIN, "year", 16'h0025);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2200);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h3, 16'h1915);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2100);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h3, 16'h0523);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h3, 16'h4459);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2000);
    unlock_cfg(16'h2300);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h2, 16'h4700);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h2200);
    rd(calendar_clock_pkg::OFS_TWIN, "month_day_value", 16'h0115);
    rd(calendar_clock_pkg::OFS_TWIN, "wdhr", 16'h0523);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h4459);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h4459);
    unlock_cfg(16'h2300);
    rd(calendar_clock_pkg::OFS_TWIN, "year", 16'h0025);
    // Alarm window walk
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'h0300);
    wr(calendar_clock_pkg::OFS_AWIN, 2'h3, 16'h5555);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h0200);
    wr(calendar_clock_pkg::OFS_AWIN, 2'h3, 16'h1231);
    wr(calendar_clock_pkg::OFS_AWIN, 2'h3, 16'h0612);
    wr(calendar_clock_pkg::OFS_AWIN, 2'h3, 16'h3015);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h0000);
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'h0200);
    rd(calendar_clock_pkg::OFS_AWIN, "almthdy", 16'h1231);
    rd(calendar_clock_pkg::OFS_AWIN, "alwdhr", 16'h0612);
    rd(calendar_clock_pkg::OFS_AWIN, "alminsec", 16'h3015);
    rd(calendar_clock_pkg::OFS_AWIN, "alminsec", 16'h3015);
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'h0100);
    wr(calendar_clock_pkg::OFS_AWIN, 2'h1, 16'h0011);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h0100);
    rd(calendar_clock_pkg::OFS_AWIN, "alwdhr", 16'h0611);
    // Reserved mask, chime and repeat count held while stopped
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'h7C05);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h7C05);
    // Output pin gating and source select
    unlock_cfg(16'h2400);
    idle(2);
    chk("oe", 16'h0001, 16'(clock_out_oe));
    chk("pin", 16'h0000, 16'(clock_out));
    wr(calendar_clock_pkg::OFS_PAD, 2'h3, 16'h0002);
    rd(calendar_clock_pkg::OFS_PAD, "pad", 16'h0002);
    idle(2);
    chk("pin", 16'h0000, 16'(clock_out));
    unlock_cfg(16'h2000);
    idle(2);
    chk("oe", 16'h0000, 16'(clock_out_oe));
    // Running clock: seconds set, calibration written, then write-enable dropped and time write ignored
    unlock_cfg(16'hA000);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h1, 16'h0059);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'hA000);
    wr(calendar_clock_pkg::OFS_CFG, 2'h1, 16'h0080);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'hA080);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, 16'h8000);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h8080);
    wr(calendar_clock_pkg::OFS_TWIN, 2'h3, 16'h1111);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h4459);
    // Running alarms: one repeat, final alarm clears enable, then chime rollover; pin shows seconds clock
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'h8001);
    wr(calendar_clock_pkg::OFS_CFG, 2'h2, 16'h8400);
    idle(20000);
    chk("pin", 16'h0001, 16'(clock_out));
    chk("alarms", 16'h0001, 16'(alarm_seen));
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h8C80);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h8000);
    idle(12730);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h9C80);
    idle(268);
    chk("alarms", 16'h0002, 16'(alarm_seen));
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'h0000);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h4500);
    chk("pin", 16'h0000, 16'(clock_out));
    wr(calendar_clock_pkg::OFS_ALCFG, 2'h3, 16'hC000);
    // Minute restarted at -512 pulses, so the half mark comes later
    idle(16378);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h8480);
    idle(400);
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h8C80);
    rd(calendar_clock_pkg::OFS_ALCFG, "alcfg", 16'hC0FF);
    chk("alarms", 16'h0003, 16'(alarm_seen));
    // Second power-on reset mid-run
    idle(1);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    rd(calendar_clock_pkg::OFS_CFG, "cfg", 16'h0000);
    rd(calendar_clock_pkg::OFS_TWIN, "minutes_seconds_value", 16'h0000);
    idle(2);
    results();
  end
endmodule // tb
